// ===== nvh_pkg.sv
// Purpose: Shared constants and carriers for the nonvolatile SRAM host controller
// Assumes: 200 MHz system clock, x16 organisation
// Notes:   Timing figures kept in their printed units, cycle counts derived here
package nvh_pkg;
    // ==========================================================================
    // Clock and timing
    // ==========================================================================
    localparam int NVH_CLK_PS = 5000;
    localparam int NVH_ACCESS_NS = 25;
    localparam int NVH_STORE_REQ_NS = 15;
    localparam int NVH_WRITE_FINISH_NS = 25;
    localparam int NVH_RELEASE_NS = 25;
    localparam int NVH_SEQ_ACTION_US = 100;
    localparam int NVH_STORE_MS = 8;
    localparam int NVH_RECALL_US = 200;
    // Least times round up
    localparam int NVH_ACCESS_CYC = (NVH_ACCESS_NS * 1000 + NVH_CLK_PS - 1) / NVH_CLK_PS;
    localparam int NVH_STORE_REQ_CYC = (NVH_STORE_REQ_NS * 1000 + NVH_CLK_PS - 1) / NVH_CLK_PS;
    localparam int NVH_RELEASE_CYC = (NVH_RELEASE_NS * 1000 + NVH_CLK_PS - 1) / NVH_CLK_PS;
    localparam int NVH_WRITE_FINISH_CYC =
        (NVH_WRITE_FINISH_NS * 1000 + NVH_CLK_PS - 1) / NVH_CLK_PS;
    // Long waits, defaults for the top-level parameters
    localparam int NVH_SEQ_ACTION_CYC = NVH_SEQ_ACTION_US * 1000000 / NVH_CLK_PS;
    localparam int NVH_RECALL_CYC = NVH_RECALL_US * 1000000 / NVH_CLK_PS;
    localparam int NVH_STORE_CYC = NVH_STORE_MS * 200000;
    localparam int NVH_CNT_W = 24;

    // ==========================================================================
    // Widths and sequence
    // ==========================================================================
    localparam int NVH_AW = 19;
    localparam int NVH_DW = 16;
    localparam int NVH_SEQ_LEN = 6;
    localparam int NVH_SEQ_LO = 2;
    localparam int NVH_SEQ_HI = 14;
    localparam logic [2:0] NVH_SEQ_LAST = 3'h5;
    // Software command addresses: fixed package constants, not overridable
    localparam logic [NVH_AW-1:0] NVH_SEQ_COMMON [0:4] = '{
        19'h00E38, 19'h031C7, 19'h003E0, 19'h03C1F, 19'h0303F};
    localparam logic [NVH_AW-1:0] NVH_SEQ_STORE = 19'h00FC0;
    localparam logic [NVH_AW-1:0] NVH_SEQ_RECALL = 19'h00C63;

    // ==========================================================================
    // Types
    // ==========================================================================
    typedef enum logic [1:0] {
        NVH_OP_READ = 2'h0,
        NVH_OP_WRITE = 2'h1,
        NVH_OP_STORE_SW = 2'h2,
        NVH_OP_RECALL_SW = 2'h3
    } nvh_op_e;

    typedef struct packed {
        nvh_op_e op;
        logic [NVH_AW-1:0] addr;
        logic [NVH_DW-1:0] wdata;
        logic [1:0] lanes;
    } nvh_req_s;

    typedef struct packed {
        logic chip_sel_n;
        logic write_en_n;
        logic out_en_n;
        logic upper_lane_en_n;
        logic lower_lane_en_n;
    } nvh_ctl_s;
endpackage : nvh_pkg

// ===== nvh_wait.sv
// Purpose: Down-counter that times a fixed wait
// Assumes: Load and count share the system clock
// Notes:   Done is a one-cycle pulse on reaching zero
`timescale 1ns/1ps
`default_nettype none
module nvh_wait
    import nvh_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_load,
    input wire logic [NVH_CNT_W-1:0] i_count,
    output logic o_busy,
    output logic o_done
);
    logic [NVH_CNT_W-1:0] cnt_q;
    logic [NVH_CNT_W-1:0] cnt_d;
    wire logic at_one = (cnt_q == NVH_CNT_W'(1));

    assign cnt_d = i_load ? i_count : (cnt_q != '0 ? cnt_q - NVH_CNT_W'(1) : cnt_q);
    assign o_busy = (cnt_q != '0);

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= '0;
            o_done <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            o_done <= at_one && !i_load;
        end
    end
endmodule : nvh_wait
`default_nettype wire

// ===== nvh_host.sv
// Purpose: Host controller driving a nonvolatile SRAM over its parallel pins
// Assumes: Device pins sampled synchronously; x16 organisation with lane enables
// Notes:   One request at a time; ready low while busy or locked out
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Write enable held high in reads
// - Store-busy kept high during accesses
// - Calendar writes via select or write enable
// - Lower lane low before select, write
// - Sequence steps are select-controlled reads
// - Six sequence reads consecutive, in order
// - Hardware store pulse at least 15 ns
module nvh_host
    import nvh_pkg::*;
#(
    parameter int P_SEQ_ACTION_CYC = NVH_SEQ_ACTION_CYC,
    parameter int P_RECALL_CYC = NVH_RECALL_CYC,
    parameter int P_STORE_CYC = NVH_STORE_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_req_valid,
    input wire nvh_req_s i_req,
    output logic o_req_ready,
    input wire logic i_hw_store,
    output logic o_rdata_valid,
    output logic [NVH_DW-1:0] o_rdata,
    output logic o_nv_busy,
    output logic [NVH_AW-1:0] o_addr,
    output nvh_ctl_s o_ctl,
    input wire logic [NVH_DW-1:0] i_dq,
    output logic [NVH_DW-1:0] o_dq,
    output logic o_dq_oe,
    input wire logic i_store_busy_n,
    output logic o_store_busy_n,
    output logic o_store_busy_oe
);
    // ==========================================================================
    // State
    // ==========================================================================
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_LANE = 7'h02,
        ST_ACC = 7'h04,
        ST_GAP = 7'h08,
        ST_HWSTR = 7'h10,
        ST_RELEASE = 7'h20,
        ST_LOCK = 7'h40
    } nvh_state_e;

    nvh_state_e st_q;
    nvh_state_e st_d;
    nvh_req_s req_q;
    logic [2:0] step_q;
    logic [NVH_CNT_W-1:0] acc_q;
    logic wt_load;
    logic [NVH_CNT_W-1:0] wt_count;
    logic wt_busy;
    logic wt_done;

    // ==========================================================================
    // Decode
    // ==========================================================================
    wire logic is_seq = (req_q.op == NVH_OP_STORE_SW) || (req_q.op == NVH_OP_RECALL_SW);
    wire logic is_wr = (req_q.op == NVH_OP_WRITE);
    wire logic dev_busy = !i_store_busy_n;
    wire logic acc_end = (acc_q == NVH_CNT_W'(NVH_ACCESS_CYC - 1));
    wire logic hw_end = (acc_q == NVH_CNT_W'(NVH_STORE_REQ_CYC - 1));
    wire logic rel_end = (acc_q == NVH_CNT_W'(NVH_RELEASE_CYC - 1));
    wire logic seq_last = (step_q == NVH_SEQ_LAST);
    wire logic [NVH_AW-1:0] seq_raw =
        seq_last ? (req_q.op == NVH_OP_STORE_SW ? NVH_SEQ_STORE : NVH_SEQ_RECALL)
                 : NVH_SEQ_COMMON[step_q];
    wire logic [NVH_AW-1:0] seq_addr;

    // Only bits 14..2 carry the command; others are driven as zero
    genvar g;
    generate
        for (g = 0; g < NVH_AW; g++) begin : g_seq_bits
            assign seq_addr[g] = (g >= NVH_SEQ_LO && g <= NVH_SEQ_HI) ? seq_raw[g] : 1'b0;
        end
    endgenerate

    // Lock length: action window plus worst store or recall duration
    wire logic [NVH_CNT_W-1:0] lock_cnt = (req_q.op == NVH_OP_STORE_SW)
        ? NVH_CNT_W'(P_SEQ_ACTION_CYC + P_STORE_CYC)
        : NVH_CNT_W'(P_SEQ_ACTION_CYC + P_RECALL_CYC);

    wire logic in_acc = (st_q == ST_ACC);
    wire logic in_lane = (st_q == ST_LANE);
    assign o_req_ready = (st_q == ST_IDLE) && !dev_busy && !i_hw_store;
    assign o_nv_busy = (st_q == ST_LOCK) || (st_q == ST_HWSTR) || (st_q == ST_RELEASE)
        || dev_busy || wt_busy;

    // Select and write enable fall together; write enable is never low before select
    always_comb begin
        o_ctl.chip_sel_n = !in_acc;
        o_ctl.write_en_n = !(in_acc && is_wr && !acc_end);
        o_ctl.out_en_n = !(in_acc && !is_wr);
        // Lanes lead select by one cycle so calendar writes see lower lane first
        o_ctl.lower_lane_en_n = !((in_lane || in_acc) && (is_seq || req_q.lanes[0]));
        o_ctl.upper_lane_en_n = !((in_lane || in_acc) && (is_seq || req_q.lanes[1]));
    end

    assign o_addr = is_seq ? seq_addr : req_q.addr;
    assign o_dq = req_q.wdata;
    assign o_dq_oe = in_acc && is_wr;
    assign o_store_busy_n = 1'b0;
    assign o_store_busy_oe = (st_q == ST_HWSTR);
    assign wt_load = (st_q == ST_GAP) && is_seq && seq_last;
    assign wt_count = lock_cnt;

    // ==========================================================================
    // Sequencer
    // ==========================================================================
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (i_hw_store && !dev_busy) begin
                    st_d = ST_HWSTR;
                end else if (i_req_valid && o_req_ready) begin
                    st_d = ST_LANE;
                end
            end
            ST_LANE: st_d = ST_ACC;
            ST_ACC: if (acc_end) st_d = ST_GAP;
            ST_GAP: st_d = (is_seq && !seq_last) ? ST_LANE : (wt_load ? ST_LOCK : ST_IDLE);
            ST_HWSTR: if (hw_end) st_d = ST_RELEASE;
            // Device may skip the store; wait out the output-active window anyway
            ST_RELEASE: if (rel_end) st_d = ST_IDLE;
            ST_LOCK: if (wt_done) st_d = ST_IDLE;
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= ST_IDLE;
            req_q <= '0;
            step_q <= 3'h0;
            acc_q <= '0;
            o_rdata <= '0;
            o_rdata_valid <= 1'b0;
        end else begin
            st_q <= st_d;
            if (st_q == ST_IDLE && st_d == ST_LANE) begin
                req_q <= i_req;
                step_q <= 3'h0;
            end else if (st_q == ST_GAP && st_d == ST_LANE) begin
                step_q <= step_q + 3'h1;
            end
            acc_q <= (st_d == st_q && st_q != ST_IDLE) ? acc_q + NVH_CNT_W'(1) : '0;
            // All six sequence reads are discarded; only plain reads return data
            o_rdata_valid <= in_acc && acc_end && (req_q.op == NVH_OP_READ);
            if (in_acc && acc_end && req_q.op == NVH_OP_READ) begin
                o_rdata <= i_dq;
            end
        end
    end

    nvh_wait u_lock (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_load(wt_load),
        .i_count(wt_count),
        .o_busy(wt_busy),
        .o_done(wt_done)
    );

    // ==========================================================================
    // Checks
    // ==========================================================================
    a_read_we_high: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (!o_ctl.out_en_n) |-> o_ctl.write_en_n)
        else $error("write enable low during read");
    a_hsb_idle_acc: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (!o_ctl.chip_sel_n) |-> !o_store_busy_oe)
        else $error("store-busy driven during access");
    a_lane_lead: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ($fell(o_ctl.chip_sel_n) && !o_ctl.lower_lane_en_n) |-> !$past(o_ctl.lower_lane_en_n))
        else $error("lower lane not ahead of select");
    a_hw_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        $rose(o_store_busy_oe) |-> o_store_busy_oe [*3])
        else $error("store pulse too short");
    a_seq_bits: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (is_seq && in_acc) |-> (o_addr[1:0] == 2'h0 && o_addr[NVH_AW-1:15] == '0))
        else $error("sequence address outside decoded bits");
    a_seq_order: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (st_q == ST_GAP && is_seq && !seq_last) |=> in_lane)
        else $error("sequence reads not consecutive");
    a_lock_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        $rose(st_q == ST_LOCK) |-> !o_req_ready [*8])
        else $error("ready during lockout");
    a_we_select: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        $fell(o_ctl.chip_sel_n) |-> !(!$past(o_ctl.write_en_n)))
        else $error("write enable low before select");
endmodule : nvh_host
`default_nettype wire

// ===== nvh_dev_model.sv
// Purpose: Behavioural nonvolatile SRAM seen from the host pins
// Assumes: x16 organisation, pins sampled on the system clock
// Notes:   Floating data toggles each cycle so stale values never match
`timescale 1ns/1ps
`default_nettype none
module nvh_dev_model
    import nvh_pkg::*;
#(
    parameter int P_STORE_CYC = 30,
    parameter int P_RECALL_CYC = 15
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [NVH_AW-1:0] i_addr,
    input wire nvh_ctl_s i_ctl,
    input wire logic [NVH_DW-1:0] i_dq,
    input wire logic i_dq_oe,
    input wire logic i_host_pull,
    output logic [NVH_DW-1:0] o_dq,
    output logic o_store_busy_n
);
    // ========================================================================
    // Decode
    // ========================================================================
    logic [NVH_DW-1:0] mem_q [0:255];
    logic [NVH_DW-1:0] junk_q;
    logic [15:0] busy_q;
    logic [2:0] step_q;
    logic cs_prev_q, wsel_q, written_q, storing_q, cs, sel_edge, rd_en;
    logic [NVH_AW-1:0] seq_a;
    logic [NVH_DW-1:0] word;
    assign cs = !i_ctl.chip_sel_n;
    assign sel_edge = cs && !cs_prev_q;
    assign seq_a = i_addr & 19'h07FFC;
    assign rd_en = cs && !i_ctl.out_en_n && i_ctl.write_en_n && !wsel_q && busy_q == 0;
    assign word = mem_q[i_addr[7:0]];
    assign o_dq[7:0] = (rd_en && !i_ctl.lower_lane_en_n) ? word[7:0] : junk_q[7:0];
    assign o_dq[15:8] = (rd_en && !i_ctl.upper_lane_en_n) ? word[15:8] : junk_q[15:8];
    // Pull-up wins unless either party pulls low
    assign o_store_busy_n = !(i_host_pull || (storing_q && busy_q != 0));
    // ========================================================================
    // Storage, sequence and lockout
    // ========================================================================
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            junk_q <= 16'h5AC3;
            busy_q <= 16'h0;
            step_q <= 3'h0;
            {cs_prev_q, wsel_q, written_q, storing_q} <= 4'h0;
        end else begin
            junk_q <= ~junk_q;
            cs_prev_q <= cs;
            if (sel_edge) begin
                wsel_q <= !i_ctl.write_en_n;
            end
            if (busy_q != 0) begin
                busy_q <= busy_q - 16'h1;
            end else if (i_host_pull && written_q) begin
                busy_q <= P_STORE_CYC[15:0];
                storing_q <= 1'b1;
                written_q <= 1'b0;
            end else if (cs && !i_ctl.write_en_n && i_dq_oe) begin
                if (!i_ctl.lower_lane_en_n) mem_q[i_addr[7:0]][7:0] <= i_dq[7:0];
                if (!i_ctl.upper_lane_en_n) mem_q[i_addr[7:0]][15:8] <= i_dq[15:8];
                written_q <= 1'b1;
            end else if (sel_edge && i_ctl.write_en_n) begin
                if (step_q < 3'h5) begin
                    step_q <= (seq_a == (NVH_SEQ_COMMON[step_q] & 19'h07FFC)) ? step_q + 3'h1 : 3'h0;
                end else begin
                    step_q <= 3'h0;
                    if (seq_a == (NVH_SEQ_STORE & 19'h07FFC)) begin
                        busy_q <= P_STORE_CYC[15:0];
                        storing_q <= 1'b1;
                        written_q <= 1'b0;
                    end else if (seq_a == (NVH_SEQ_RECALL & 19'h07FFC)) begin
                        busy_q <= P_RECALL_CYC[15:0];
                        storing_q <= 1'b0;
                    end
                end
            end
        end
    end
endmodule : nvh_dev_model
`default_nettype wire

// ===== nvh_host_tb.sv
// Purpose: Self-checking bench for the nonvolatile SRAM host controller
// Assumes: Small lock parameters so stores finish in tens of cycles
// Notes:   Device model stands on the pins
`timescale 1ns/1ps
`default_nettype none
module nvh_host_tb
    import nvh_pkg::*;
;
    logic clk, rst_n, req_valid, hw_store, ready, rdata_valid, nv_busy, dq_oe, pin, sb_o, sb_oe;
    nvh_req_s req;
    nvh_ctl_s ctl;
    logic [NVH_DW-1:0] rdata, dev_dq, host_dq;
    logic [NVH_AW-1:0] addr;
    int errors, checks_done;
    nvh_host #(.P_SEQ_ACTION_CYC(20), .P_RECALL_CYC(20), .P_STORE_CYC(40)) DUT (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_req_valid(req_valid), .i_req(req),
        .o_req_ready(ready), .i_hw_store(hw_store), .o_rdata_valid(rdata_valid),
        .o_rdata(rdata), .o_nv_busy(nv_busy), .o_addr(addr), .o_ctl(ctl), .i_dq(dev_dq),
        .o_dq(host_dq), .o_dq_oe(dq_oe), .i_store_busy_n(pin), .o_store_busy_n(sb_o),
        .o_store_busy_oe(sb_oe));
    nvh_dev_model #(.P_STORE_CYC(30), .P_RECALL_CYC(15)) u_dev (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr), .i_ctl(ctl), .i_dq(host_dq),
        .i_dq_oe(dq_oe), .i_host_pull(sb_oe && !sb_o), .o_dq(dev_dq), .o_store_busy_n(pin));
    always #2.5 clk = ~clk;
    // ========================================================================
    // Shared tasks
    // ========================================================================
    task automatic tally_and_finish();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic send(input nvh_op_e op, input logic [NVH_AW-1:0] a,
                        input logic [NVH_DW-1:0] d, input logic [1:0] ln);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{op, a, d, ln};
        n = 0;
        do begin @(posedge clk); n++; end while (ready !== 1'b1 && n < 300);
        req_valid <= 1'b0;
    endtask : send
    task automatic wait_ready(output int n);
        n = 0;
        do begin @(negedge clk); n++; end while (ready !== 1'b1 && n < 400);
    endtask : wait_ready
    // ========================================================================
    // Scenarios
    // ========================================================================
    task automatic t_rw(input logic [NVH_AW-1:0] a, input logic [NVH_DW-1:0] d,
                        input logic [1:0] ln, input logic [NVH_DW-1:0] exp);
        int n;
        send(NVH_OP_WRITE, a, d, ln);
        wait_ready(n);
        send(NVH_OP_READ, a, 16'h0, 2'h3);
        for (n = 0; n < 20 && rdata_valid !== 1'b1; n++) begin
            @(negedge clk);
            if (ctl.out_en_n === 1'b0) begin
                chk(ctl.write_en_n, 1'b1);
                chk(sb_oe, 1'b0);
            end
        end
        chk(rdata, exp);
    endtask : t_rw
    task automatic t_seq(input nvh_op_e op, input logic [NVH_AW-1:0] last);
        int k, n;
        logic cs_prev;
        send(op, 19'h7FFFF, 16'h0, 2'h0);
        k = 0;
        cs_prev = 1'b1;
        for (n = 0; n < 100 && k < 6; n++) begin
            @(negedge clk);
            if (ctl.chip_sel_n === 1'b0 && cs_prev) begin
                if (k < 5) chk(addr, NVH_SEQ_COMMON[k] & 19'h07FFC);
                else chk(addr, last & 19'h07FFC);
                chk({ctl.write_en_n, ctl.upper_lane_en_n, ctl.lower_lane_en_n}, 3'h4);
                k++;
            end
            cs_prev = ctl.chip_sel_n;
        end
        chk(k, 6);
        // Recall leaves the pin high, so only the lock state proves busy here
        repeat (6) @(negedge clk);
        chk({nv_busy, ready}, 2'h2);
        wait_ready(n);
        chk(n > 20, 1'b1);
    endtask : t_seq
    task automatic t_hw(input logic long);
        int n, m;
        @(posedge clk);
        hw_store <= 1'b1;
        @(posedge clk);
        hw_store <= 1'b0;
        n = 0;
        repeat (20) begin
            @(negedge clk);
            if (sb_oe === 1'b1) n++;
        end
        chk(n, 3);
        chk(nv_busy, long);
        wait_ready(m);
        chk(m > 5, long);
    endtask : t_hw
    // ========================================================================
    // Main sequence
    // ========================================================================
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        hw_store = 1'b0;
        errors = 0;
        checks_done = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk({ctl, dq_oe, sb_oe, ready}, {5'h1F, 3'h1});
        t_rw(19'h00010, 16'hBEEF, 2'h3, 16'hBEEF);
        t_rw(19'h00010, 16'h1234, 2'h1, 16'hBE34);
        t_rw(19'h00010, 16'h7700, 2'h2, 16'h7734);
        t_seq(NVH_OP_STORE_SW, NVH_SEQ_STORE);
        t_seq(NVH_OP_RECALL_SW, NVH_SEQ_RECALL);
        t_hw(1'b0);
        t_rw(19'h00020, 16'h0F0F, 2'h3, 16'h0F0F);
        t_hw(1'b1);
        tally_and_finish();
    end
endmodule : nvh_host_tb
`default_nettype wire
